// *** pkg/bit_op_consts.svh ***
// Constants of the bit-manipulation execute unit
`ifndef BIT_OP_CONSTS_SVH
`define BIT_OP_CONSTS_SVH
`define OPCODE_HI 13
`define OPCODE_LO 10
`define BIT_HI 9
`define BIT_LO 7
`define ADDR_HI 6
`define ADDR_LO 0
`define OPC_CLEAR 4'h4
`define OPC_SET 4'h5
`define OPC_TEST 4'h6
`define NOP_WORD 14'h0000
`endif

// *** pkg/bit_op_pkg.sv ***
// Types of the bit-manipulation execute unit
package bit_op_pkg;
  typedef enum logic [2:0] {
    ST_EXEC = 3'h1,
    ST_SKIP = 3'h2,
    ST_IDLE = 3'h4
  } exec_state_type;
endpackage

// *** logic/bit_op_execute_unit.sv ***
// Decode and execute of the bit clear, bit set and bit test-skip instructions
// Behaviour
// - Opcode 0100: write zero into bit b of file register f.
// - Opcode 0101: write one into bit b, other bits unchanged.
// - Opcode 0110: test bit b of f; skip next only if zero.
// - On skip, the prefetched next word is discarded and never takes effect.
// - A skip executes a no-operation cycle; one word, two cycles when skipping.
`timescale 1ns/10ps
`default_nettype none
`include "bit_op_consts.svh"
module bit_op_execute_unit (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic [7:0] file_rd_data,
  output logic [6:0] file_addr,
  output logic file_wr_en,
  output logic [7:0] file_wr_data,
  output logic skip_taken,
  output logic busy,
  output logic [13:0] exec_word,
  output logic flags_wr_en
);

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  // One-hot mask of the addressed bit
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  // Opcode compare, shared by the three decoders
  function automatic logic opcode_is(
    input logic [13:0] word,
    input logic [3:0] code
  );
    opcode_is = (word[`OPCODE_HI:`OPCODE_LO] == code);
  endfunction

  // Byte with the masked bit forced to the given level
  function automatic logic [7:0] modify_byte(
    input logic [7:0] value,
    input logic [7:0] bit_sel,
    input logic level
  );
    if (level)
      modify_byte = value | bit_sel;
    else
      modify_byte = value & ~bit_sel;
  endfunction

  // True when the masked bit reads zero
  function automatic logic bit_reads_zero(
    input logic [7:0] value,
    input logic [7:0] bit_sel
  );
    bit_reads_zero = ((value & bit_sel) == 8'h00);
  endfunction

  // ------------------------------------------------------------
  // Decoded fields
  // ------------------------------------------------------------
  logic [2:0] bit_idx;
  logic [6:0] addr;
  logic [7:0] mask;
  logic word_taken;
  logic is_clear;
  logic is_set;
  logic is_test;
  logic do_skip;
  bit_op_pkg::exec_state_type state_q;
  bit_op_pkg::exec_state_type state_d;

  assign bit_idx = instr_word[`BIT_HI:`BIT_LO];
  assign addr = instr_word[`ADDR_HI:`ADDR_LO];
  assign mask = bit_mask(bit_idx);
  // A word arriving in the no-operation cycle is swallowed
  assign word_taken = instr_valid && (state_q != bit_op_pkg::ST_SKIP);
  assign is_clear = word_taken && opcode_is(instr_word, `OPC_CLEAR);
  assign is_set = word_taken && opcode_is(instr_word, `OPC_SET);
  assign is_test = word_taken && opcode_is(instr_word, `OPC_TEST);
  // Skip only when the tested bit reads zero
  assign do_skip = is_test && bit_reads_zero(file_rd_data, mask);

  // ------------------------------------------------------------
  // Skip sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    case (state_q)
      bit_op_pkg::ST_IDLE,
      bit_op_pkg::ST_EXEC:
        state_d = do_skip ? bit_op_pkg::ST_SKIP : bit_op_pkg::ST_EXEC;
      // Second cycle of a skip always returns to execution
      bit_op_pkg::ST_SKIP:
        state_d = bit_op_pkg::ST_EXEC;
      default:
        state_d = bit_op_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= bit_op_pkg::ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // File register address
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      file_addr <= 7'h00;
    end
    else
    begin
      file_addr <= addr;
    end
  end

  // ------------------------------------------------------------
  // File register write strobe
  // ------------------------------------------------------------
  // Read-modify-write lands one cycle after decode
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      file_wr_en <= 1'b0;
    end
    else
    begin
      file_wr_en <= is_clear || is_set;
    end
  end

  // ------------------------------------------------------------
  // File register write data
  // ------------------------------------------------------------
  // Other bits pass through unchanged
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      file_wr_data <= 8'h00;
    end
    else if (is_clear)
    begin
      file_wr_data <= modify_byte(file_rd_data, mask, 1'b0);
    end
    else if (is_set)
    begin
      file_wr_data <= modify_byte(file_rd_data, mask, 1'b1);
    end
    else
    begin
      file_wr_data <= file_rd_data;
    end
  end

  // ------------------------------------------------------------
  // Skip status
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      skip_taken <= 1'b0;
    end
    else
    begin
      skip_taken <= do_skip;
    end
  end

  // ------------------------------------------------------------
  // Busy during the no-operation cycle
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
    end
    else
    begin
      busy <= do_skip;
    end
  end

  // ------------------------------------------------------------
  // Executed word
  // ------------------------------------------------------------
  // Prefetched word replaced by a no-operation
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exec_word <= `NOP_WORD;
    end
    else if (!word_taken)
    begin
      exec_word <= `NOP_WORD;
    end
    else
    begin
      exec_word <= instr_word;
    end
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  // Bit operations never write carry, digit carry or zero
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_wr_en <= 1'b0;
    end
    else
    begin
      flags_wr_en <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** verification/file_model.sv ***
// Register file partner
`timescale 1ns/10ps
`default_nettype none
module file_model(input wire logic sys_clk,we,input wire logic [6:0] a,wa,
  input wire logic [7:0] d,output logic [7:0] q);
  logic [7:0] m[128];
  initial for(int i=0;i<128;i++) m[i]=8'(i*8'h25);
  always @(posedge sys_clk) if(we) m[wa]<=d;
  assign q=we&&wa==a?d:m[a];
endmodule
`default_nettype wire

// *** verification/bit_op_execute_unit_assertions.sv ***
// Bit op unit checker
`timescale 1ns/10ps
`default_nettype none
module bit_op_chk(input wire logic sys_clk,rst_n,instr_valid,file_wr_en,skip_taken,busy,
  flags_wr_en,input wire logic [13:0] instr_word,exec_word,
  input wire logic [7:0] file_rd_data,file_wr_data);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic [3:0] o=instr_valid&&!busy?instr_word[13:10]:4'h0;
  wire logic [7:0] m=8'h01<<instr_word[9:7];
  wire logic [7:0] n=instr_word[10]?file_rd_data|m:file_rd_data&~m;
  wire logic z=n==file_rd_data;
  a_clear_bit: assert property(o==4'h4|=>file_wr_en&&file_wr_data==$past(n))
    else $error("clear");
  a_set_bit: assert property(o==4'h5|=>file_wr_en&&file_wr_data==$past(n))
    else $error("set");
  a_test_skip: assert property(o==4'h6|=>!file_wr_en&&skip_taken==$past(z))
    else $error("test");
  a_skip_drop: assert property(skip_taken|=>!file_wr_en&&exec_word==14'h0000)
    else $error("drop");
  a_nop_busy: assert property(skip_taken|->busy##1!busy) else $error("busy");
  a_no_flags: assert property(!flags_wr_en) else $error("flags");
  cover property(o==4'h4);
  cover property(o==4'h5);
  cover property(skip_taken);
endmodule
bind bit_op_execute_unit bit_op_chk chk(.*);
`default_nettype wire

// *** verification/tb_bit_op_execute_unit.sv ***
// Bit op unit bench
`timescale 1ns/10ps
`default_nettype none
module tb_bit_op_execute_unit;
  logic sys_clk=0,rst_n=0,v=0,sk=0,we,ns,wen,skp,bsy,fl;
  logic [13:0] w=0,ew;
  logic [7:0] rd,wd,dv;
  logic [6:0] fa;
  logic [16:0] r=17'h12D93;
  logic [32:0] q[$],e;
  int err_count=0,n_checks=0;
  function automatic logic [16:0] nx(logic [16:0] x);
    return {x[15:0],x[16]^x[13]};
  endfunction
  bit_op_execute_unit dut(.sys_clk,.rst_n,.instr_valid(v),.instr_word(w),.file_rd_data(rd),
    .file_addr(fa),.file_wr_en(wen),.file_wr_data(wd),.skip_taken(skp),.busy(bsy),
    .exec_word(ew),.flags_wr_en(fl));
  file_model fm(.sys_clk,.we(wen),.a(w[6:0]),.wa(fa),.d(wd),.q(rd));
  initial forever #5 sys_clk=~sys_clk;
  task automatic cmp(string s,logic [17:0] x,g);
    n_checks++;
    if(g!==x)
    begin
      err_count++;
      $display("BAD %s exp %h got %h",s,x,g);
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d",err_count,n_checks);
    if(err_count==0&&n_checks>0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat(3) @(posedge sys_clk);
    #1 rst_n=1;
    repeat(500)
    begin
      @(posedge sys_clk);
      #1 r=nx(r);
      v=r[0]|r[5];
      w={2'h1,r[12:1]};
      #1 we=v&&!sk&&!w[11];
      ns=v&&!sk&&w[11:10]==2'h2&&!rd[w[9:7]];
      dv=w[10]?rd|8'h01<<w[9:7]:rd&~(8'h01<<w[9:7]);
      q.push_back({we,ns,ns,1'b0,v&&!sk?w:14'h0000,w[6:0],dv});
      sk=ns;
    end
    repeat(2) @(posedge sys_clk);
    conclude();
  end
  initial
  forever
  begin
    @(posedge sys_clk);
    #0.5 if(q.size()>0)
    begin
      e=q.pop_front();
      cmp("ctl",e[32:15],{wen,skp,bsy,fl,ew});
      if(e[32]) cmp("wr",e[14:0],{fa,wd});
    end
  end
endmodule
`default_nettype wire
